// >>> host_port_pkg.sv
// Constants and types shared by both ends of the host port link
// Functional notes
// - Select low qualifies every addressed register access
// - Read strobe reads, write strobe writes registers
// - Fly-by DMA swaps read and write strobes
// - Strobe plus grant low enables data bus
// - Access-done marks completed register access
// - Host holds access until access-done
// - FIFO DMA accesses complete without access-done
// - Shared access-done needs bit 4 set
// - Interrupt output driven by enabled conditions only
// - Channel 0 request when FIFO ready
// - Async FIFO mode: request carries service request
// - Stream valid output, polarity from mode
// - Boot configuration sampled during reset
// - Grant accepts request, then transfer proceeds
// - Unused DMA keeps grant high always
// - Host holds pins high during reset
// - Data bus 32 bits, address 4 bits
// - Stream hold input, polarity programmable
package host_port_pkg;
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 32;
  localparam int EVT_W    = 8;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS   = 4;
  localparam int SYNC_NS  = 12;
  localparam int SYNC_CYC = (SYNC_NS + CLK_NS - 1) / CLK_NS;
  localparam int DMA_CYC  = 2;
  // ---------------------------------------------------------------
  // Device registers, word index on the 4-bit address
  // ---------------------------------------------------------------
  localparam logic [3:0] R_FIFO0  = 4'h0;
  localparam logic [3:0] R_IRQ_EN = 4'h1;
  localparam logic [3:0] R_IRQ_ST = 4'h2;
  localparam logic [3:0] R_MODE   = 4'h3;
  localparam logic [3:0] R_PLL_HIGH_CONFIG = 4'h4;
  localparam logic [3:0] R_BOOT   = 4'h5;
  localparam int M_DMA_EN   = 0;
  localparam int M_FLYBY    = 1;
  localparam int M_ASYNC    = 2;
  localparam int M_VALID_LO = 3;
  localparam int M_HOLD_LO  = 4;
  localparam int P_ACK_SHARE = 4;
  localparam logic [31:0] REG_RST = 32'h0;
  // ---------------------------------------------------------------
  // Controller registers on AXI4-Lite, byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CMD    = 8'h00;
  localparam logic [7:0] A_WDATA  = 8'h04;
  localparam logic [7:0] A_RDATA  = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0c;
  localparam logic [7:0] A_IRQ_ST = 8'h10;
  localparam logic [7:0] A_IRQ_MK = 8'h14;
  localparam logic [7:0] A_CTRL   = 8'h18;
  localparam int C_WRITE = 8;
  localparam int C_DMA   = 9;
  localparam int K_BOOT  = 0;
  localparam int K_DMA   = 1;
  typedef enum logic [1:0] {
    D_IDLE = 2'b00, D_SYNC = 2'b01, D_DONE = 2'b10
  } dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_SETUP = 3'b001, H_STROBE = 3'b010,
    H_RELEASE = 3'b011
  } host_state_t;
endpackage

// >>> hp_link_if.sv
// Pin-level link between host controller and codec host port
`timescale 1ns/1ps
`default_nettype none
interface hp_link_if;
  logic        cs_n;
  logic        rd_n;
  logic        we_n;
  logic [3:0]  addr;
  logic [31:0] hd_to_dev;
  logic        hd_host_oe_n;
  logic [31:0] hd_to_host;
  logic        hd_dev_oe_n;
  logic        ack_out;
  logic        ack_oe_n;
  logic        irq_n;
  logic        dma_request_ch0;
  logic        dma_grant_ch0_n;
  logic        stream_valid;
  logic        stream_hold;
  logic        boot_cfg;
  modport dev (
    input  cs_n, rd_n, we_n, addr, hd_to_dev, hd_host_oe_n,
    input  dma_grant_ch0_n, stream_hold, boot_cfg,
    output hd_to_host, hd_dev_oe_n, ack_out, ack_oe_n, irq_n,
    output dma_request_ch0, stream_valid
  );
  modport host (
    output cs_n, rd_n, we_n, addr, hd_to_dev, hd_host_oe_n,
    output dma_grant_ch0_n, stream_hold, boot_cfg,
    input  hd_to_host, hd_dev_oe_n, ack_out, ack_oe_n, irq_n,
    input  dma_request_ch0, stream_valid
  );
endinterface // hp_link_if
`default_nettype wire

// >>> hp_device.sv
// Codec end of the host port: registers, access-done, DMA handshake
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module hp_device (
  input  wire logic                               aclk,
  input  wire logic                               aresetn,
  hp_link_if.dev                                  link,
  input  wire logic [host_port_pkg::EVT_W-1:0]    irq_events,
  input  wire logic                               fifo0_ready,
  input  wire logic [host_port_pkg::DATA_W-1:0]   fifo0_rdata,
  input  wire logic                               stream_word_valid,
  output logic                                    fifo0_wr,
  output logic                                    fifo0_rd,
  output logic [host_port_pkg::DATA_W-1:0]        fifo0_wdata,
  output logic                                    stream_paused,
  output logic [host_port_pkg::DATA_W-1:0]        mode_out,
  output logic                                    boot_mode
);
  import host_port_pkg::*;

  // ---------------------------------------------------------------
  // Strobe decode
  // ---------------------------------------------------------------
  logic [31:0] mode_q;
  logic [31:0] pll_q;
  logic [31:0] irq_en_q;
  logic [31:0] irq_st_q;
  logic        rd_pin;
  logic        we_pin;
  logic        grant;
  logic        dma_rd;
  logic        dma_wr;
  logic        dma_act;
  logic        dma_act_q;
  logic        reg_req;
  logic        released;

  assign rd_pin = ~link.rd_n;
  assign we_pin = ~link.we_n;
  assign grant  = ~link.dma_grant_ch0_n;
  assign dma_rd = mode_q[M_FLYBY] ? we_pin : rd_pin;
  assign dma_wr = mode_q[M_FLYBY] ? rd_pin : we_pin;
  assign dma_act = grant & (dma_rd | dma_wr);
  // Grant low marks a DMA cycle, so registers need select low with grant high
  assign reg_req = ~link.cs_n & ~grant & (rd_pin | we_pin);
  assign released = link.cs_n | (~rd_pin & ~we_pin);

  // ---------------------------------------------------------------
  // Register access sequencer
  // ---------------------------------------------------------------
  dev_state_t  state_q;
  logic [1:0]  cnt_q;
  logic [3:0]  addr_q;
  logic        write_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic        boot_q;
  logic        commit;

  assign commit = (state_q == D_SYNC) && (cnt_q == 2'(SYNC_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= D_IDLE;
      cnt_q   <= 2'h0;
      addr_q  <= 4'h0;
      write_q <= 1'b0;
      wdata_q <= REG_RST;
    end else begin
      case (state_q)
        D_IDLE: begin
          if (reg_req) begin
            state_q <= D_SYNC;
            cnt_q   <= 2'h0;
            addr_q  <= link.addr;
            write_q <= we_pin;
            wdata_q <= link.hd_to_dev;
          end
        end
        D_SYNC: begin
          // Stands in for the internal clock-domain crossing delay
          if (commit) begin
            state_q <= D_DONE;
          end else begin
            cnt_q <= cnt_q + 2'h1;
          end
        end
        D_DONE: begin
          if (released) begin
            state_q <= D_IDLE;
          end
        end
        default: begin
          state_q <= D_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic wr_hit;
  assign wr_hit = commit & write_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q   <= REG_RST;
      pll_q    <= REG_RST;
      irq_en_q <= REG_RST;
    end else if (wr_hit) begin
      case (addr_q)
        R_MODE:   mode_q   <= wdata_q;
        R_PLL_HIGH_CONFIG: pll_q    <= wdata_q;
        R_IRQ_EN: irq_en_q <= wdata_q;
        default: begin
        end
      endcase
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_q <= REG_RST;
    end else begin
      irq_st_q <= (irq_st_q & ~((wr_hit && addr_q == R_IRQ_ST) ?
                  wdata_q : 32'h0)) | {24'h0, irq_events};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= REG_RST;
    end else if (commit && !write_q) begin
      case (addr_q)
        R_FIFO0:  rdata_q <= fifo0_rdata;
        R_IRQ_EN: rdata_q <= irq_en_q;
        R_IRQ_ST: rdata_q <= irq_st_q;
        R_MODE:   rdata_q <= mode_q;
        R_PLL_HIGH_CONFIG: rdata_q <= pll_q;
        R_BOOT:   rdata_q <= {31'h0, boot_q};
        default:  rdata_q <= REG_RST;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Boot strap, caught while reset is low
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_q <= link.boot_cfg;
    end
  end

  // ---------------------------------------------------------------
  // Data bus and access-done
  // ---------------------------------------------------------------
  logic        hd_oe_n_q;
  logic [31:0] hd_q;
  logic        ack_q;
  logic        ack_oe_n_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hd_oe_n_q <= 1'b1;
      hd_q      <= REG_RST;
    end else begin
      // Enabled by any strobe with grant, DMA channel enabled or not
      hd_oe_n_q <= ~((grant & (rd_pin | we_pin)) |
                     (state_q == D_DONE && !write_q && rd_pin &&
                      !link.cs_n));
      hd_q      <= grant ? fifo0_rdata : rdata_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_q      <= 1'b1;
      ack_oe_n_q <= 1'b0;
    end else begin
      ack_q      <= ~(state_q == D_DONE && !released);
      // Shared line: drive only the low level, pull-up gives the high
      ack_oe_n_q <= pll_q[P_ACK_SHARE] ? ~(state_q == D_DONE && !released) : 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // FIFO DMA strobes and channel 0 request
  // ---------------------------------------------------------------
  logic req_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dma_act_q   <= 1'b0;
      fifo0_wr    <= 1'b0;
      fifo0_rd    <= 1'b0;
      fifo0_wdata <= REG_RST;
    end else begin
      dma_act_q   <= dma_act;
      // One FIFO word per strobe, no wait on access-done
      fifo0_wr    <= dma_act & ~dma_act_q & dma_wr;
      fifo0_rd    <= dma_act & ~dma_act_q & dma_rd;
      fifo0_wdata <= link.hd_to_dev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_q <= 1'b0;
    end else if (mode_q[M_ASYNC]) begin
      req_q <= fifo0_ready;
    end else if (grant) begin
      req_q <= 1'b0;
    end else begin
      req_q <= mode_q[M_DMA_EN] & fifo0_ready;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt, stream qualifiers, boot level
  // ---------------------------------------------------------------
  logic irq_n_q;
  logic valid_q;
  logic pause_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_n_q <= 1'b1;
      valid_q <= 1'b0;
      pause_q <= 1'b0;
    end else begin
      irq_n_q <= ~|(irq_st_q & irq_en_q);
      valid_q <= stream_word_valid ^ mode_q[M_VALID_LO];
      pause_q <= link.stream_hold ^ mode_q[M_HOLD_LO];
    end
  end

  assign link.hd_to_host      = hd_q;
  assign link.hd_dev_oe_n     = hd_oe_n_q;
  assign link.ack_out         = ack_q;
  assign link.ack_oe_n        = ack_oe_n_q;
  assign link.irq_n           = irq_n_q;
  assign link.dma_request_ch0 = req_q;
  assign link.stream_valid    = valid_q;
  assign stream_paused        = pause_q;
  assign mode_out             = mode_q;
  assign boot_mode            = boot_q;
endmodule // hp_device
`default_nettype wire

// >>> hp_host.sv
// Host controller end: AXI4-Lite registers driving the host port pins
`timescale 1ns/1ps
`default_nettype none
module hp_host (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  hp_link_if.host          link
);
  import host_port_pkg::*;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic [7:0]  awaddr_q;
  logic [31:0] wd_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic        do_wr;
  logic [9:0]  cmd_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [1:0]  irq_st_q;
  logic [1:0]  irq_mk_q;
  logic [1:0]  ctrl_q;
  logic        start;
  logic        done;
  host_state_t state_q;

  assign do_wr = aw_have_q & w_have_q & ~s_axi_bvalid;
  // Full-word registers; byte enables other than all-ones are ignored, except by the A_IRQ_ST write-one clear
  assign start = do_wr && awaddr_q == A_CMD && s_axi_wstrb == 4'hf && state_q == H_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 8'h0;
      wd_q          <= REG_RST;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_have_q & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_have_q & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wd_q     <= s_axi_wdata;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_bresp = 2'b00;
  assign s_axi_rresp = 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_q    <= 10'h0;
      wdata_q  <= REG_RST;
      irq_mk_q <= 2'h0;
      ctrl_q   <= 2'h0;
    end else if (do_wr && s_axi_wstrb == 4'hf) begin
      case (awaddr_q)
        A_CMD:    if (state_q == H_IDLE) cmd_q <= wd_q[9:0];
        A_WDATA:  wdata_q  <= wd_q;
        A_IRQ_MK: irq_mk_q <= wd_q[1:0];
        A_CTRL:   ctrl_q   <= wd_q[1:0];
        default: begin
        end
      endcase
    end
  end

  // Set wins over write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_q <= 2'h0;
      irq      <= 1'b0;
    end else begin
      irq_st_q <= (irq_st_q & ~((do_wr && awaddr_q == A_IRQ_ST) ?
                  wd_q[1:0] : 2'h0)) | {~link.irq_n, done};
      irq      <= |(irq_st_q & irq_mk_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= REG_RST;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        case (s_axi_araddr)
          A_CMD:    s_axi_rdata <= {22'h0, cmd_q};
          A_WDATA:  s_axi_rdata <= wdata_q;
          A_RDATA:  s_axi_rdata <= rdata_q;
          A_STATUS: s_axi_rdata <= {29'h0, link.dma_request_ch0, ~link.irq_n, state_q != H_IDLE};
          A_IRQ_ST: s_axi_rdata <= {30'h0, irq_st_q};
          A_IRQ_MK: s_axi_rdata <= {30'h0, irq_mk_q};
          A_CTRL:   s_axi_rdata <= {30'h0, ctrl_q};
          default:  s_axi_rdata <= REG_RST;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin sequencer
  // ---------------------------------------------------------------
  logic ack_low;
  logic [1:0] cnt_q;
  assign ack_low = ~link.ack_oe_n & ~link.ack_out;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= H_IDLE;
      cnt_q   <= 2'h0;
      done    <= 1'b0;
      rdata_q <= REG_RST;
      link.cs_n <= 1'b1;
      link.rd_n <= 1'b1;
      link.we_n <= 1'b1;
      link.dma_grant_ch0_n <= 1'b1;
      link.hd_host_oe_n <= 1'b1;
      link.addr <= 4'h0;
      link.hd_to_dev <= REG_RST;
    end else begin
      done <= 1'b0;
      case (state_q)
        H_IDLE: begin
          if (start) begin
            state_q <= H_SETUP;
            link.addr <= wd_q[3:0];
            link.hd_to_dev <= wdata_q;
            link.hd_host_oe_n <= ~wd_q[C_WRITE];
            link.cs_n <= wd_q[C_DMA];
          end
        end
        H_SETUP: begin
          cnt_q <= 2'h0;
          if (!cmd_q[C_DMA]) begin
            state_q <= H_STROBE;
            link.we_n <= ~cmd_q[C_WRITE];
            link.rd_n <= cmd_q[C_WRITE];
          end else if (ctrl_q[K_DMA] && link.dma_request_ch0) begin
            state_q <= H_STROBE;
            link.dma_grant_ch0_n <= 1'b0;
            link.we_n <= ~cmd_q[C_WRITE];
            link.rd_n <= cmd_q[C_WRITE];
          end
        end
        H_STROBE: begin
          cnt_q <= cnt_q + 2'h1;
          if (cmd_q[C_DMA] ? cnt_q == 2'(DMA_CYC - 1) : ack_low) begin
            state_q <= H_RELEASE;
            if (!cmd_q[C_WRITE]) rdata_q <= link.hd_to_host;
            link.rd_n <= 1'b1;
            link.we_n <= 1'b1;
          end
        end
        H_RELEASE: begin
          state_q <= H_IDLE;
          done <= 1'b1;
          link.cs_n <= 1'b1;
          link.dma_grant_ch0_n <= 1'b1;
          link.hd_host_oe_n <= 1'b1;
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.boot_cfg <= 1'b0;
      link.stream_hold <= 1'b0;
    end else begin
      link.boot_cfg <= ctrl_q[K_BOOT];
      link.stream_hold <= 1'b0;
    end
  end
endmodule // hp_host
`default_nettype wire

// >>> hp_link_monitor.sv
// Concurrent checks on the pins between host controller and codec port
`timescale 1ns/1ps
`default_nettype none
module hp_link_monitor (
  input wire logic                             aclk,
  input wire logic                             aresetn,
  input wire logic                             cs_n,
  input wire logic                             rd_n,
  input wire logic                             we_n,
  input wire logic                             ack_out,
  input wire logic                             ack_oe_n,
  input wire logic                             hd_dev_oe_n,
  input wire logic                             dma_grant_ch0_n,
  input wire logic                             dma_request_ch0,
  input wire logic                             fifo0_ready,
  input wire logic [host_port_pkg::DATA_W-1:0] mode_out
);
  import host_port_pkg::*;
  logic ack_line;
  logic strobe;
  // Pull-up wins whenever the device lets go of the line
  assign ack_line = ack_oe_n | ack_out;
  assign strobe   = !(rd_n && we_n);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ---------------------------------------------------------------
  // Access-done timing
  // ---------------------------------------------------------------
  ack_wait_a: assert property ($rose(strobe) && !cs_n && dma_grant_ch0_n |-> ack_line ##1 ack_line ##[1:5] !ack_line)
    else $error("access-done early or missing");
  ack_stand_a: assert property (!ack_line && strobe && !cs_n |=> !ack_line)
    else $error("access-done dropped while strobe held");
  ack_free_a: assert property (!strobe |=> ack_line)
    else $error("access-done low with strobes released");
  host_hold_a: assert property (strobe && !cs_n && dma_grant_ch0_n && ack_line |=> strobe && !cs_n)
    else $error("host released before access-done");
  // ---------------------------------------------------------------
  // Data bus and DMA request
  // ---------------------------------------------------------------
  rd_drive_a: assert property (!ack_line && !rd_n && !cs_n && !mode_out[M_FLYBY] |-> !hd_dev_oe_n)
    else $error("read data not driven");
  bus_idle_a: assert property (cs_n && dma_grant_ch0_n && $past(cs_n && dma_grant_ch0_n) |-> hd_dev_oe_n)
    else $error("bus driven while unselected");
  dma_bus_a: assert property (!dma_grant_ch0_n && strobe ##1 !dma_grant_ch0_n && strobe |-> !hd_dev_oe_n)
    else $error("bus idle during granted strobe");
  grant_clr_a: assert property (!mode_out[M_ASYNC] && !dma_grant_ch0_n |=> !dma_request_ch0)
    else $error("request kept after grant");
  async_req_a: assert property (mode_out[M_ASYNC] && $past(mode_out[M_ASYNC]) |-> dma_request_ch0 == $past(fifo0_ready))
    else $error("service request does not follow fifo");
endmodule // hp_link_monitor
`default_nettype wire

// >>> async_host_port_dma_handshake_tb.sv
// Bench joining host controller and codec port, driven over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module async_host_port_dma_handshake_tb;
  import host_port_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        fifo0_wr, fifo0_rd, stream_paused, boot_mode;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, fifo0_wdata, mode_out, d;
  logic [7:0]  irq_events = 8'h00;
  logic        fifo0_ready = 1'b0;
  logic        word_valid = 1'b0;
  logic [31:0] fifo0_rdata = 32'h5a5a_c3c3;
  int          n_errors = 0;
  int          compares = 0;
  int          cycles = 0;
  int          n_rd = 0;
  int          n_wr = 0;

  hp_link_if link ();
  hp_host u_hp_host (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .link(link.host));
  hp_device u_hp_device (.aclk(aclk), .aresetn(aresetn), .link(link.dev), .irq_events(irq_events),
    .fifo0_ready(fifo0_ready), .fifo0_rdata(fifo0_rdata), .stream_word_valid(word_valid),
    .fifo0_wr(fifo0_wr), .fifo0_rd(fifo0_rd), .fifo0_wdata(fifo0_wdata), .stream_paused(stream_paused),
    .mode_out(mode_out), .boot_mode(boot_mode));
  hp_link_monitor u_hp_link_monitor (.aclk(aclk), .aresetn(aresetn), .cs_n(link.cs_n), .rd_n(link.rd_n),
    .we_n(link.we_n), .ack_out(link.ack_out), .ack_oe_n(link.ack_oe_n), .hd_dev_oe_n(link.hd_dev_oe_n),
    .dma_grant_ch0_n(link.dma_grant_ch0_n), .dma_request_ch0(link.dma_request_ch0),
    .fifo0_ready(fifo0_ready), .mode_out(mode_out));

  always #2 aclk = ~aclk;

  // ---------------------------------------------------------------
  // Pulse counters and hang guard
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    cycles++;
    if (aresetn) begin
      n_rd += int'(fifo0_rd);
      n_wr += int'(fifo0_wr);
    end
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report;
    $display("Compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // AXI4-Lite master
  // ---------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // One link transfer through the controller; r holds the captured word
  task automatic link_op(input logic [3:0] i, input logic w, input logic dma, input logic [31:0] v,
                         output logic [31:0] r);
    logic [31:0] s;
    axi_wr(A_WDATA, v);
    axi_wr(A_CMD, {22'h0, dma, w, 4'h0, i});
    do axi_rd(A_STATUS, s); while (s[0] !== 1'b0);
    axi_rd(A_RDATA, r);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    check("reset pins", 32'({link.cs_n, link.rd_n, link.we_n, link.dma_grant_ch0_n, link.irq_n,
          link.ack_out | link.ack_oe_n, link.dma_request_ch0}), 32'h7e);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check("boot mode", 32'(boot_mode), 32'h0);
    link_op(R_MODE, 1'b0, 1'b0, 32'h0, d);
    check("mode reset", d, REG_RST);
    link_op(R_IRQ_EN, 1'b1, 1'b0, 32'h0000_00a5, d);
    link_op(R_IRQ_EN, 1'b0, 1'b0, 32'h0, d);
    check("irq enable", d, 32'h0000_00a5);
    link_op(R_PLL_HIGH_CONFIG, 1'b1, 1'b0, 32'h1 << P_ACK_SHARE, d);
    link_op(R_PLL_HIGH_CONFIG, 1'b0, 1'b0, 32'h0, d);
    check("pll high", d, 32'h0000_0010);
    link_op(R_BOOT, 1'b0, 1'b0, 32'h0, d);
    check("boot strap", d, 32'h0);
    axi_rd(8'h1c, d);
    check("unmapped", d, 32'h0);
    // Done event raised, then unmasked, then cleared
    axi_rd(A_IRQ_ST, d);
    check("done flag", d & 32'h1, 32'h1);
    axi_wr(A_IRQ_MK, 32'h1);
    check("irq on", 32'(irq), 32'h1);
    axi_wr(A_IRQ_ST, 32'h1);
    check("irq cleared", 32'(irq), 32'h0);
    axi_wr(A_IRQ_MK, 32'h0);
    // Disabled source first: it must not reach the pin
    irq_events <= 8'h02;
    @(posedge aclk);
    irq_events <= 8'h00;
    repeat (4) @(posedge aclk);
    check("irq masked", 32'(link.irq_n), 32'h1);
    irq_events <= 8'h01;
    @(posedge aclk);
    irq_events <= 8'h00;
    repeat (4) @(posedge aclk);
    check("irq raised", 32'(link.irq_n), 32'h0);
    link_op(R_IRQ_ST, 1'b1, 1'b0, 32'h3, d);
    check("irq released", 32'(link.irq_n), 32'h1);
    check("host irq masked", 32'(irq), 32'h0);
    // Stream qualifier and hold polarity
    word_valid <= 1'b1;
    link_op(R_MODE, 1'b1, 1'b0, 32'h0, d);
    check("valid high", 32'(link.stream_valid), 32'h1);
    link_op(R_MODE, 1'b1, 1'b0, 32'h18, d);
    check("valid low", 32'(link.stream_valid), 32'h0);
    check("paused", 32'(stream_paused), 32'h1);
    // Service request follows the fifo in async mode
    link_op(R_MODE, 1'b1, 1'b0, 32'h4, d);
    fifo0_ready <= 1'b1;
    repeat (3) @(posedge aclk);
    check("service on", 32'(link.dma_request_ch0), 32'h1);
    fifo0_ready <= 1'b0;
    repeat (3) @(posedge aclk);
    check("service off", 32'(link.dma_request_ch0), 32'h0);
    // Handshaked DMA, plain then fly-by
    axi_wr(A_CTRL, 32'h2);
    link_op(R_MODE, 1'b1, 1'b0, 32'h1, d);
    fifo0_ready <= 1'b1;
    repeat (3) @(posedge aclk);
    check("request", 32'(link.dma_request_ch0), 32'h1);
    link_op(R_FIFO0, 1'b0, 1'b1, 32'h0, d);
    check("dma read data", d, 32'h5a5a_c3c3);
    check("fifo reads", 32'(n_rd), 32'h1);
    link_op(R_FIFO0, 1'b1, 1'b1, 32'h1234_5678, d);
    check("fifo wdata", fifo0_wdata, 32'h1234_5678);
    check("fifo writes", 32'(n_wr), 32'h1);
    link_op(R_MODE, 1'b1, 1'b0, 32'h3, d);
    link_op(R_FIFO0, 1'b1, 1'b1, 32'h0bad_f00d, d);
    check("flyby reads", 32'(n_rd), 32'h2);
    check("flyby writes", 32'(n_wr), 32'h1);
    final_report();
  end
endmodule // async_host_port_dma_handshake_tb
`default_nettype wire
